// File: src/crf_core.v
// Purpose: CPU register file, status flags and data-space map.
// Assumes: Decoder and ALU control share CLK; one request per cycle.
// Notes: Flags and register contents are never saved on interrupt entry.
// Overview of operation
// - Next instruction word fetched while current instruction executes.
// - Thirty-two 8-bit registers, each read or written in one cycle.
// - Two operands read, computed and written back in one cycle.
// - Six registers form three 16-bit pointers; one also addresses program tables.
// - Status flags updated after every ALU operation except MOV.
// - Status flags not saved or restored around interrupts by hardware.
// - Global enable bit 7 clear blocks every interrupt.
// - Taking an interrupt clears global enable; interrupt return sets it.
// - Set-interrupt instruction sets, clear-interrupt instruction clears global enable.
// - Bit 6 stores a register bit on store, writes it back on load.
// - Bit 5 holds half carry out of low nibble.
// - Bit 4 is set to negative xor overflow by each flag-writing ALU operation.
// - Bit 3 flags two's complement overflow.
// - Bits 2, 1, 0 flag negative, zero and carry results.
// - Port schemes: 8r/8w, two 8r/8w, two 8r/16w, 16r/16w.
// - Registers occupy the first 32 data-space addresses.
// - 64 I/O addresses follow the registers in data space.
// - Competing interrupts served lowest vector first.
// - Instructions are one or two 16-bit words.
// - Registers 26 to 31 are the three pointer pairs.
`timescale 1ns/1ns
`include "crf_consts.vh"

module crf_core
#(
  parameter NUM_IRQ = 16,
  parameter PC_W = 12
)
(
  input wire CLK,
  input wire RESET_N,
  input wire [4:0] RD_ADDR,
  input wire [4:0] RR_ADDR,
  input wire [3:0] ALU_OP,
  input wire USE_IMM,
  input wire [7:0] IMM,
  input wire [5:0] WORD_K,
  input wire WR_EN,
  input wire WR_WIDE,
  input wire BIT_STORE,
  input wire BIT_LOAD,
  input wire [2:0] BIT_SEL,
  input wire SET_GIE,
  input wire CLEAR_GIE,
  input wire RETURN_FROM_INTERRUPT,
  input wire STATUS_WR,
  input wire [7:0] STATUS_WDATA,
  input wire [NUM_IRQ-1:0] IRQ_PENDING,
  input wire DS_EN,
  input wire DS_WE,
  input wire [15:0] DS_ADDR,
  input wire [7:0] DS_WDATA,
  input wire [7:0] IO_RDATA,
  input wire IS_TWO_WORD,
  input wire ADVANCE,
  input wire [15:0] PM_DATA,
  output reg [7:0] RD_DATA,
  output reg [7:0] RR_DATA,
  output reg [7:0] CPU_STATUS_FLAGS,
  output reg [15:0] PTR_X,
  output reg [15:0] PTR_Y,
  output reg [15:0] PTR_Z,
  output reg [15:0] TABLE_ADDR,
  output reg IRQ_TAKE,
  output reg [4:0] IRQ_VECTOR,
  output reg [7:0] DS_RDATA,
  output reg IO_EN,
  output reg IO_WE,
  output reg [5:0] IO_ADDR,
  output reg [7:0] IO_WDATA,
  output reg [PC_W-1:0] PM_ADDR,
  output reg [31:0] INSTR,
  output reg INSTR_VALID
);
  reg [7:0] regs_q [0:`CRF_NUM_REGS-1];
  reg [7:0] status_q;
  reg [7:0] status_d;
  reg [7:0] op_b;
  reg [15:0] wide_rd;
  reg wr_lo;
  reg wr_hi;
  reg [7:0] wdata_lo;
  reg [7:0] wdata_hi;
  reg [4:0] wr_addr;
  reg ds_reg_hit;
  reg ds_io_hit;
  reg irq_found;
  reg [4:0] irq_idx;
  reg [7:0] ds_rd_d;
  wire [15:0] alu_res;
  wire [5:0] alu_flags;
  wire [5:0] alu_we;
  wire [PC_W-1:0] fetch_addr;
  wire [31:0] fetch_instr;
  wire fetch_valid;
  integer i;
  integer j;

  function [15:0] pair;
    input [4:0] lo;
    begin
      pair = {regs_q[lo + 5'h01], regs_q[lo]};
    end
  endfunction

  crf_alu u_alu
  (
    .op(ALU_OP),
    .a(regs_q[RD_ADDR]),
    .b(op_b),
    .wa(wide_rd),
    .wk(WORD_K),
    .c_in(status_q[`CRF_FLAG_C]),
    .z_in(status_q[`CRF_FLAG_Z]),
    .res(alu_res),
    .flags(alu_flags),
    .flag_we(alu_we)
  );

  crf_fetch #(.PC_W(PC_W)) u_fetch
  (
    .clk(CLK),
    .reset_n(RESET_N),
    .advance(ADVANCE),
    .is_two_word(IS_TWO_WORD),
    .pm_data(PM_DATA),
    .pm_addr(fetch_addr),
    .instr(fetch_instr),
    .instr_valid(fetch_valid)
  );

  // Lowest index means lowest vector, hence highest priority
  always @*
  begin
    irq_found = 1'b0;
    irq_idx = 5'h00;
    for (i = NUM_IRQ - 1; i >= 0; i = i - 1)
      if (IRQ_PENDING[i])
      begin
        irq_found = 1'b1;
        irq_idx = i[4:0];
      end
  end

  always @*
  begin
    op_b = USE_IMM ? IMM : regs_q[RR_ADDR];
    wide_rd = {regs_q[RD_ADDR | 5'h01], regs_q[RD_ADDR & 5'h1E]};
    ds_reg_hit = DS_EN && (DS_ADDR <= `CRF_DS_REG_LAST);
    ds_io_hit = DS_EN && (DS_ADDR >= `CRF_DS_IO_FIRST) && (DS_ADDR <= `CRF_DS_IO_LAST);
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_addr = RD_ADDR & 5'h1E;
    wdata_lo = alu_res[7:0];
    wdata_hi = alu_res[15:8];
    if (ds_reg_hit && DS_WE)
    begin
      wr_lo = 1'b1;
      wr_addr = DS_ADDR[4:0];
      wdata_lo = DS_WDATA;
    end
    else if (BIT_LOAD)
    begin
      wr_lo = 1'b1;
      wr_addr = RD_ADDR;
      wdata_lo = regs_q[RD_ADDR];
      wdata_lo[BIT_SEL] = status_q[`CRF_FLAG_T];
    end
    else if (WR_EN && WR_WIDE)
    begin
      wr_lo = 1'b1;
      wr_hi = 1'b1;
    end
    else if (WR_EN)
    begin
      wr_lo = 1'b1;
      wr_addr = RD_ADDR;
    end
    ds_rd_d = 8'h00;
    if (ds_reg_hit)
      ds_rd_d = regs_q[DS_ADDR[4:0]];
    else if (ds_io_hit)
      ds_rd_d = IO_RDATA;
  end

  // Interrupt take has priority over an explicit enable in same cycle
  always @*
  begin
    status_d = status_q;
    if (STATUS_WR)
      status_d = STATUS_WDATA;
    if (alu_we[5]) status_d[`CRF_FLAG_H] = alu_flags[5];
    if (alu_we[4]) status_d[`CRF_FLAG_S] = alu_flags[4];
    if (alu_we[3]) status_d[`CRF_FLAG_V] = alu_flags[3];
    if (alu_we[2]) status_d[`CRF_FLAG_N] = alu_flags[2];
    if (alu_we[1]) status_d[`CRF_FLAG_Z] = alu_flags[1];
    if (alu_we[0]) status_d[`CRF_FLAG_C] = alu_flags[0];
    if (BIT_STORE)
      status_d[`CRF_FLAG_T] = regs_q[RD_ADDR][BIT_SEL];
    if (SET_GIE || RETURN_FROM_INTERRUPT)
      status_d[`CRF_FLAG_I] = 1'b1;
    if (CLEAR_GIE)
      status_d[`CRF_FLAG_I] = 1'b0;
    if (status_q[`CRF_FLAG_I] && irq_found && !CLEAR_GIE)
      status_d[`CRF_FLAG_I] = 1'b0;
  end

  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      for (j = 0; j < `CRF_NUM_REGS; j = j + 1)
        regs_q[j] <= 8'h00;
      status_q <= `CRF_STATUS_RESET;
      RD_DATA <= 8'h00;
      RR_DATA <= 8'h00;
      CPU_STATUS_FLAGS <= `CRF_STATUS_RESET;
      PTR_X <= 16'h0000;
      PTR_Y <= 16'h0000;
      PTR_Z <= 16'h0000;
      TABLE_ADDR <= 16'h0000;
      IRQ_TAKE <= 1'b0;
      IRQ_VECTOR <= 5'h00;
      DS_RDATA <= 8'h00;
      IO_EN <= 1'b0;
      IO_WE <= 1'b0;
      IO_ADDR <= 6'h00;
      IO_WDATA <= 8'h00;
      PM_ADDR <= {PC_W{1'b0}};
      INSTR <= 32'h00000000;
      INSTR_VALID <= 1'b0;
    end
    else
    begin
      if (wr_lo)
        regs_q[wr_addr] <= wdata_lo;
      if (wr_hi)
        regs_q[wr_addr | 5'h01] <= wdata_hi;
      // No save of flags on interrupt entry; software keeps them
      status_q <= status_d;
      CPU_STATUS_FLAGS <= status_d;
      RD_DATA <= regs_q[RD_ADDR];
      RR_DATA <= regs_q[RR_ADDR];
      PTR_X <= pair(`CRF_PTR_X_LO);
      PTR_Y <= pair(`CRF_PTR_Y_LO);
      PTR_Z <= pair(`CRF_PTR_Z_LO);
      TABLE_ADDR <= pair(`CRF_PTR_Z_LO);
      IRQ_TAKE <= status_q[`CRF_FLAG_I] && irq_found && !CLEAR_GIE;
      IRQ_VECTOR <= irq_idx;
      DS_RDATA <= ds_rd_d;
      IO_EN <= ds_io_hit;
      IO_WE <= ds_io_hit && DS_WE;
      IO_ADDR <= DS_ADDR[5:0] - 6'h20;
      IO_WDATA <= DS_WDATA;
      PM_ADDR <= fetch_addr;
      INSTR <= fetch_instr;
      INSTR_VALID <= fetch_valid;
    end
  end
endmodule

// File: src/crf_consts.vh
// Purpose: Constants for the CPU register file and status flag block.
// Assumes: Included by the crf_* design files and the dv bench files.
// Notes: Bit positions of the status flags and data-space map boundaries.
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH

`define CRF_NUM_REGS 32
`define CRF_FLAG_I 7
`define CRF_FLAG_T 6
`define CRF_FLAG_H 5
`define CRF_FLAG_S 4
`define CRF_FLAG_V 3
`define CRF_FLAG_N 2
`define CRF_FLAG_Z 1
`define CRF_FLAG_C 0
`define CRF_STATUS_RESET 8'h00
`define CRF_PTR_X_LO 5'h1A
`define CRF_PTR_Y_LO 5'h1C
`define CRF_PTR_Z_LO 5'h1E
`define CRF_DS_REG_LAST 16'h001F
`define CRF_DS_IO_FIRST 16'h0020
`define CRF_DS_IO_LAST 16'h005F
`define CRF_NUM_IO 64

`define CRF_OP_NONE 4'h0
`define CRF_OP_ADD 4'h1
`define CRF_OP_ADC 4'h2
`define CRF_OP_SUB 4'h3
`define CRF_OP_SBC 4'h4
`define CRF_OP_AND 4'h5
`define CRF_OP_OR 4'h6
`define CRF_OP_XOR 4'h7
`define CRF_OP_MOV 4'h8
`define CRF_OP_ADIW 4'h9
`define CRF_OP_SBIW 4'hA
`define CRF_OP_INC 4'hB
`define CRF_OP_DEC 4'hC

`endif

// File: src/crf_alu.v
// Purpose: Combinational ALU producing a result and the status flags.
// Assumes: Operands arrive from the register file in the same cycle.
// Notes: 16-bit word add and subtract use the pair form of Rd and a 6-bit constant.
`timescale 1ns/1ns
`include "crf_consts.vh"

module crf_alu
(
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire [15:0] wa,
  input wire [5:0] wk,
  input wire c_in,
  input wire z_in,
  output reg [15:0] res,
  output reg [5:0] flags,
  output reg [5:0] flag_we
);
  reg [8:0] sum;
  reg [4:0] nib;
  reg [16:0] wsum;
  reg v;
  reg h;
  reg n;
  reg z;
  reg c;

  always @*
  begin
    sum = 9'h000;
    nib = 5'h00;
    wsum = 17'h00000;
    v = 1'b0;
    h = 1'b0;
    c = 1'b0;
    res = 16'h0000;
    flag_we = 6'h00;
    case (op)
      `CRF_OP_ADD, `CRF_OP_ADC:
      begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, (op == `CRF_OP_ADC) & c_in};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == `CRF_OP_ADC) & c_in};
        res = {8'h00, sum[7:0]};
        h = nib[4];
        v = (a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]);
        c = sum[8];
        flag_we = 6'h3F;
      end
      `CRF_OP_SUB, `CRF_OP_SBC:
      begin
        sum = {1'b0, a} - {1'b0, b} - {8'h00, (op == `CRF_OP_SBC) & c_in};
        nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, (op == `CRF_OP_SBC) & c_in};
        res = {8'h00, sum[7:0]};
        h = nib[4];
        v = (a[7] & ~b[7] & ~sum[7]) | (~a[7] & b[7] & sum[7]);
        c = sum[8];
        flag_we = 6'h3F;
      end
      `CRF_OP_AND, `CRF_OP_OR, `CRF_OP_XOR:
      begin
        res[7:0] = (op == `CRF_OP_AND) ? (a & b) : (op == `CRF_OP_OR) ? (a | b) : (a ^ b);
        flag_we = 6'h1E;
      end
      `CRF_OP_INC, `CRF_OP_DEC:
      begin
        res[7:0] = (op == `CRF_OP_INC) ? a + 8'h01 : a - 8'h01;
        v = (op == `CRF_OP_INC) ? (a == 8'h7F) : (a == 8'h80);
        flag_we = 6'h1E;
      end
      `CRF_OP_ADIW, `CRF_OP_SBIW:
      begin
        wsum = (op == `CRF_OP_ADIW) ? {1'b0, wa} + {11'h000, wk} : {1'b0, wa} - {11'h000, wk};
        res = wsum[15:0];
        v = (op == `CRF_OP_ADIW) ? (~wa[15] & wsum[15]) : (wa[15] & ~wsum[15]);
        c = wsum[16];
        flag_we = 6'h1F;
      end
      `CRF_OP_MOV:
        res[7:0] = b;
      default:
        res = 16'h0000;
    endcase
    n = (op == `CRF_OP_ADIW || op == `CRF_OP_SBIW) ? res[15] : res[7];
    z = (op == `CRF_OP_ADIW || op == `CRF_OP_SBIW) ? (res == 16'h0000) : (res[7:0] == 8'h00);
    if (op == `CRF_OP_SBC)
      z = z & z_in;
    // Order: H S V N Z C
    flags = {h, n ^ v, v, n, z, c};
  end
endmodule

// File: src/crf_fetch.v
// Purpose: Single-level prefetch stage for one- and two-word instructions.
// Assumes: Program memory answers in the cycle after the address is given.
// Notes: The decoder marks two-word opcodes so the first word is held until the second arrives.
`timescale 1ns/1ns
`include "crf_consts.vh"

module crf_fetch
#(
  parameter PC_W = 12
)
(
  input wire clk,
  input wire reset_n,
  input wire advance,
  input wire is_two_word,
  input wire [15:0] pm_data,
  output wire [PC_W-1:0] pm_addr,
  output wire [31:0] instr,
  output wire instr_valid
);
  reg [PC_W-1:0] pc_q;
  reg [15:0] first_q;
  reg have_first_q;
  reg valid_q;

  assign pm_addr = pc_q;
  assign instr = have_first_q ? {first_q, pm_data} : {pm_data, 16'h0000};
  assign instr_valid = valid_q & (have_first_q | ~is_two_word);

  // Next word fetched while current one executes
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      pc_q <= {PC_W{1'b0}};
      first_q <= 16'h0000;
      have_first_q <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= 1'b1;
      if (valid_q && advance)
      begin
        pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
        if (!have_first_q && is_two_word)
        begin
          first_q <= pm_data;
          have_first_q <= 1'b1;
        end
        else
          have_first_q <= 1'b0;
      end
    end
  end
endmodule

// File: dv/crf_far_model.sv
// Purpose: Far-side stand-in giving program words and I/O read data.
// Assumes: Program memory answers one cycle after the address.
// Notes: Read data is a pattern of the address, so a stale value shows.
`timescale 1ns/1ns
module crf_far_model
(
  input wire clk,
  input wire [11:0] pm_addr,
  input wire [15:0] ds_addr,
  output reg [15:0] pm_data,
  output wire [7:0] io_rdata
);
  always @(posedge clk)
    pm_data <= {4'h5, pm_addr};
  // Inverted address, never a constant that could hide a missed read
  assign io_rdata = ~ds_addr[7:0];
endmodule

// File: dv/crf_core_sva.sv
// Purpose: Port-level checks for the register file and status block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Status bits are I T H S V N Z C from bit 7 down.
`timescale 1ns/1ns
`include "crf_consts.vh"
module crf_core_sva
#(
  parameter NUM_IRQ = 16
)
(
  input wire CLK,
  input wire RESET_N,
  input wire [3:0] ALU_OP,
  input wire BIT_STORE,
  input wire [2:0] BIT_SEL,
  input wire SET_GIE,
  input wire CLEAR_GIE,
  input wire RETURN_FROM_INTERRUPT,
  input wire [NUM_IRQ-1:0] IRQ_PENDING,
  input wire DS_EN,
  input wire DS_WE,
  input wire [15:0] DS_ADDR,
  input wire [7:0] RD_DATA,
  input wire [7:0] CPU_STATUS_FLAGS,
  input wire [15:0] PTR_Z,
  input wire [15:0] TABLE_ADDR,
  input wire IRQ_TAKE,
  input wire [4:0] IRQ_VECTOR,
  input wire IO_EN,
  input wire IO_WE,
  input wire [5:0] IO_ADDR
);
  // Scan from the top so the lowest pending index wins
  function automatic [4:0] low_idx(input [NUM_IRQ-1:0] p);
    low_idx = 5'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
      if (p[i])
        low_idx = i[4:0];
  endfunction
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_reset_clear: assert property ($rose(RESET_N) |-> CPU_STATUS_FLAGS == 8'h00)
    else $error("status not clear after reset");
  a_sign_xor: assert property ((ALU_OP != `CRF_OP_NONE && ALU_OP != `CRF_OP_MOV) |=>
    CPU_STATUS_FLAGS[4] == (CPU_STATUS_FLAGS[2] ^ CPU_STATUS_FLAGS[3])) else $error("sign flag wrong");
  a_gie_clear: assert property (CLEAR_GIE |=> !CPU_STATUS_FLAGS[7] && !IRQ_TAKE)
    else $error("clear of global enable failed");
  a_gie_set: assert property ((SET_GIE || RETURN_FROM_INTERRUPT) && !CLEAR_GIE &&
    !(CPU_STATUS_FLAGS[7] && |IRQ_PENDING) |=> CPU_STATUS_FLAGS[7]) else $error("global enable not set");
  a_gate_irq: assert property (!CPU_STATUS_FLAGS[7] |=> !IRQ_TAKE)
    else $error("interrupt taken while disabled");
  a_take_lowest: assert property (CPU_STATUS_FLAGS[7] && !CLEAR_GIE && |IRQ_PENDING |=>
    IRQ_TAKE && !CPU_STATUS_FLAGS[7] && IRQ_VECTOR == low_idx($past(IRQ_PENDING))) else $error("bad take");
  a_store_bit: assert property (BIT_STORE |=> CPU_STATUS_FLAGS[6] == RD_DATA[$past(BIT_SEL)])
    else $error("copy bit not stored");
  a_io_map: assert property (DS_EN && DS_ADDR >= 16'h0020 && DS_ADDR <= 16'h005F |=> IO_EN &&
    IO_WE == $past(DS_WE) && IO_ADDR == ($past(DS_ADDR[5:0]) ^ 6'h20)) else $error("io forward wrong");
  a_reg_space: assert property (DS_EN && DS_ADDR <= 16'h001F |=> !IO_EN)
    else $error("register access leaked to io");
  a_table_ptr: assert property (TABLE_ADDR == PTR_Z)
    else $error("table pointer differs");
  c_take: cover property (IRQ_TAKE);
  c_store: cover property (BIT_STORE);
  c_io_write: cover property (IO_EN && IO_WE);
endmodule
bind crf_core crf_core_sva #(.NUM_IRQ(NUM_IRQ)) u_sva
(
  .CLK(CLK), .RESET_N(RESET_N), .ALU_OP(ALU_OP), .BIT_STORE(BIT_STORE), .BIT_SEL(BIT_SEL),
  .SET_GIE(SET_GIE), .CLEAR_GIE(CLEAR_GIE), .RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT),
  .IRQ_PENDING(IRQ_PENDING), .DS_EN(DS_EN), .DS_WE(DS_WE), .DS_ADDR(DS_ADDR), .RD_DATA(RD_DATA),
  .CPU_STATUS_FLAGS(CPU_STATUS_FLAGS), .PTR_Z(PTR_Z), .TABLE_ADDR(TABLE_ADDR), .IRQ_TAKE(IRQ_TAKE),
  .IRQ_VECTOR(IRQ_VECTOR), .IO_EN(IO_EN), .IO_WE(IO_WE), .IO_ADDR(IO_ADDR)
);

// File: dv/test_crf_core.sv
// Purpose: Self-checking bench for the register file and status block.
// Assumes: Inputs change 1 ns after each rising CLK.
// Notes: Fetch inputs are held; each of dsw, dsr, rd and op leaves one idle cycle after it.
`timescale 1ns/1ns
`include "crf_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_crf_core;
  reg CLK = 1'b0, RESET_N = 1'b0;
  reg [4:0] RD_ADDR, RR_ADDR;
  reg [3:0] ALU_OP;
  reg [5:0] WORD_K;
  reg [2:0] BIT_SEL;
  reg WR_EN, WR_WIDE, BIT_STORE, BIT_LOAD, SET_GIE, CLEAR_GIE, RETURN_FROM_INTERRUPT, STATUS_WR, DS_EN, DS_WE;
  reg [7:0] STATUS_WDATA, DS_WDATA;
  reg USE_IMM, IS_TWO_WORD, ADVANCE;
  reg [7:0] IMM;
  reg [11:0] pc_seen;
  reg [15:0] IRQ_PENDING, DS_ADDR;
  wire [7:0] RD_DATA, RR_DATA, CPU_STATUS_FLAGS, DS_RDATA, IO_WDATA, IO_RDATA;
  wire [15:0] PTR_X, PTR_Y, PTR_Z, TABLE_ADDR, PM_DATA;
  wire IRQ_TAKE, IO_EN, IO_WE, INSTR_VALID;
  wire [4:0] IRQ_VECTOR;
  wire [5:0] IO_ADDR;
  wire [11:0] PM_ADDR;
  wire [31:0] INSTR;
  int bad_count = 0;
  int samples_checked = 0;
  always #20 CLK = ~CLK;
  crf_far_model far (.clk(CLK), .pm_addr(PM_ADDR), .ds_addr(DS_ADDR), .pm_data(PM_DATA), .io_rdata(IO_RDATA));
  crf_core #(.NUM_IRQ(16), .PC_W(12)) dut
  (
    .CLK(CLK), .RESET_N(RESET_N), .RD_ADDR(RD_ADDR), .RR_ADDR(RR_ADDR), .ALU_OP(ALU_OP), .USE_IMM(USE_IMM),
    .IMM(IMM), .WORD_K(WORD_K), .WR_EN(WR_EN), .WR_WIDE(WR_WIDE), .BIT_STORE(BIT_STORE), .BIT_LOAD(BIT_LOAD),
    .BIT_SEL(BIT_SEL), .SET_GIE(SET_GIE), .CLEAR_GIE(CLEAR_GIE), .RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT),
    .STATUS_WR(STATUS_WR), .STATUS_WDATA(STATUS_WDATA), .IRQ_PENDING(IRQ_PENDING), .DS_EN(DS_EN), .DS_WE(DS_WE),
    .DS_ADDR(DS_ADDR), .DS_WDATA(DS_WDATA), .IO_RDATA(IO_RDATA), .IS_TWO_WORD(IS_TWO_WORD), .ADVANCE(ADVANCE),
    .PM_DATA(PM_DATA), .RD_DATA(RD_DATA), .RR_DATA(RR_DATA), .CPU_STATUS_FLAGS(CPU_STATUS_FLAGS), .PTR_X(PTR_X),
    .PTR_Y(PTR_Y), .PTR_Z(PTR_Z), .TABLE_ADDR(TABLE_ADDR), .IRQ_TAKE(IRQ_TAKE), .IRQ_VECTOR(IRQ_VECTOR),
    .DS_RDATA(DS_RDATA), .IO_EN(IO_EN), .IO_WE(IO_WE), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
    .PM_ADDR(PM_ADDR), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID)
  );
  function automatic [7:0] pat(input int i);
    pat = 8'((i * 7) + 3);
  endfunction
  task tick;
    @(posedge CLK);
    #1;
  endtask
  task idle;
    {WR_EN, WR_WIDE, BIT_STORE, BIT_LOAD, SET_GIE, CLEAR_GIE, RETURN_FROM_INTERRUPT, STATUS_WR, DS_EN, DS_WE} = 10'h000;
    {RD_ADDR, RR_ADDR, ALU_OP, WORD_K, BIT_SEL} = 23'h000000;
    {STATUS_WDATA, DS_WDATA, DS_ADDR} = 32'h00000000;
    {USE_IMM, IMM} = 9'h000;
  endtask
  // Idle cycle after each request, so no signal is driven twice in one step
  task fin;
    idle;
    tick;
  endtask
  task dsw(input [15:0] a, input [7:0] d);
    DS_ADDR = a;
    DS_WDATA = d;
    DS_EN = 1'b1;
    DS_WE = 1'b1;
    tick;
    fin;
  endtask
  task dsr(input [15:0] a, input [7:0] e);
    DS_ADDR = a;
    DS_EN = 1'b1;
    tick;
    `CHK(DS_RDATA, e)
    fin;
  endtask
  task rd(input [4:0] r, input [7:0] e);
    RD_ADDR = r;
    RR_ADDR = r;
    tick;
    `CHK(RD_DATA, e)
    `CHK(RR_DATA, e)
    fin;
  endtask
  task op(input [3:0] o, input [4:0] d, input [4:0] r, input [7:0] e);
    ALU_OP = o;
    RD_ADDR = d;
    RR_ADDR = r;
    WR_EN = 1'b1;
    tick;
    `CHK(CPU_STATUS_FLAGS, e)
    fin;
  endtask
  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    give_verdict;
  end
  initial
  begin
    idle;
    IRQ_PENDING = 16'h0000;
    {IS_TWO_WORD, ADVANCE} = 2'b01;
    repeat (6) @(posedge CLK);
    #1 RESET_N = 1'b1;
    `CHK(CPU_STATUS_FLAGS, `CRF_STATUS_RESET)
    for (int i = 0; i < 32; i++) dsw(i[15:0], pat(i));
    for (int i = 0; i < 32; i++) rd(i[4:0], pat(i));
    `CHK(PTR_X, {pat(27), pat(26)})
    `CHK(PTR_Y, {pat(29), pat(28)})
    `CHK(TABLE_ADDR, {pat(31), pat(30)})
    $display("register map test done");
    dsw(16'h0001, 8'h7F);
    dsw(16'h0002, 8'h01);
    dsw(16'h0003, 8'hFF);
    dsw(16'h0004, 8'h00);
    op(`CRF_OP_ADD, 5'h01, 5'h02, 8'h2C);
    rd(5'h01, 8'h80);
    op(`CRF_OP_ADD, 5'h03, 5'h02, 8'h23);
    rd(5'h03, 8'h00);
    op(`CRF_OP_SUB, 5'h04, 5'h02, 8'h35);
    rd(5'h04, 8'hFF);
    op(`CRF_OP_AND, 5'h01, 5'h01, 8'h35);
    USE_IMM = 1'b1;
    IMM = 8'h10;
    op(`CRF_OP_ADD, 5'h03, 5'h00, 8'h00);
    rd(5'h03, 8'h10);
    $display("alu flag test done");
    dsw(16'h001A, 8'hFF);
    ALU_OP = `CRF_OP_ADIW;
    RD_ADDR = 5'h1A;
    WORD_K = 6'h01;
    WR_EN = 1'b1;
    WR_WIDE = 1'b1;
    tick;
    fin;
    `CHK(PTR_X, {8'(pat(27) + 8'h01), 8'h00})
    dsr(16'h001B, 8'(pat(27) + 8'h01));
    $display("wide write test done");
    STATUS_WR = 1'b1;
    STATUS_WDATA = 8'h01;
    tick;
    `CHK(CPU_STATUS_FLAGS, 8'h01)
    fin;
    dsw(16'h0005, 8'h08);
    dsw(16'h0006, 8'h00);
    RD_ADDR = 5'h05;
    BIT_SEL = 3'h3;
    BIT_STORE = 1'b1;
    tick;
    `CHK(CPU_STATUS_FLAGS, 8'h41)
    fin;
    RD_ADDR = 5'h06;
    BIT_LOAD = 1'b1;
    tick;
    fin;
    rd(5'h06, 8'h01);
    $display("bit copy test done");
    IRQ_PENDING = 16'h0006;
    tick;
    `CHK(IRQ_TAKE, 1'b0)
    SET_GIE = 1'b1;
    tick;
    `CHK(CPU_STATUS_FLAGS, 8'hC1)
    fin;
    `CHK(IRQ_TAKE, 1'b1)
    `CHK(IRQ_VECTOR, 5'h01)
    `CHK(CPU_STATUS_FLAGS, 8'h41)
    IRQ_PENDING = 16'h8000;
    SET_GIE = 1'b1;
    tick;
    SET_GIE = 1'b0;
    CLEAR_GIE = 1'b1;
    tick;
    `CHK(IRQ_TAKE, 1'b0)
    `CHK(CPU_STATUS_FLAGS, 8'h41)
    fin;
    IRQ_PENDING = 16'h0000;
    RETURN_FROM_INTERRUPT = 1'b1;
    tick;
    `CHK(CPU_STATUS_FLAGS, 8'hC1)
    fin;
    $display("interrupt enable test done");
    DS_ADDR = 16'h005F;
    DS_WDATA = 8'hA5;
    DS_EN = 1'b1;
    DS_WE = 1'b1;
    tick;
    `CHK({IO_EN, IO_WE, IO_ADDR, IO_WDATA}, {2'b11, 6'h3F, 8'hA5})
    fin;
    dsr(16'h0020, 8'hDF);
    dsr(16'h0060, 8'h00);
    $display("data space test done");
    ADVANCE = 1'b0;
    tick;
    ADVANCE = 1'b1;
    pc_seen = PM_ADDR;
    tick;
    `CHK(PM_ADDR, pc_seen)
    tick;
    `CHK(PM_ADDR, 12'(pc_seen + 12'h001))
    IS_TWO_WORD = 1'b1;
    tick;
    `CHK(INSTR_VALID, 1'b0)
    IS_TWO_WORD = 1'b0;
    tick;
    `CHK({INSTR_VALID, INSTR[31:28], INSTR[15:12]}, {1'b1, 4'h5, 4'h5})
    tick;
    `CHK({INSTR_VALID, INSTR[31:28], INSTR[15:0]}, {1'b1, 4'h5, 16'h0000})
    $display("fetch test done");
    give_verdict;
  end
endmodule
